/* src/ubrg_consts.svh */
// Constants for the serial baud generator and port enable block.
// Assumes inclusion by bare name from the design file.
`ifndef UBRG_CONSTS_SVH
`define UBRG_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define UBRG_OFS_RX_CTRL 8'h18
`define UBRG_OFS_TX_CTRL 8'h98
`define UBRG_OFS_DIVISOR 8'h99
`define UBRG_OFS_PORT_DIR 8'hA0
`define UBRG_OFS_INT_STAT 8'hA1
`define UBRG_OFS_INT_CLR 8'hA2
`define UBRG_OFS_INT_EN 8'hA3

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UBRG_RX_SERIAL_EN 7
`define UBRG_RX_NINE 6
`define UBRG_RX_SINGLE 5
`define UBRG_RX_CONT 4
`define UBRG_RX_ADDR_DET 3
`define UBRG_RX_FRAME 2
`define UBRG_RX_OVERRUN 1
`define UBRG_RX_NINTH_BIT 0
`define UBRG_TX_CLK_SRC 7
`define UBRG_TX_SYNC 4
`define UBRG_TX_RSVD 3
`define UBRG_TX_HIGH_SPEED 2
`define UBRG_TX_SHIFT_EMPTY 1
`define UBRG_DIR_RX_PIN 1
`define UBRG_DIR_TX_PIN 2
`define UBRG_INT_OVERRUN 0
`define UBRG_INT_FRAME 1
`define UBRG_INT_NUM 2

// ----------------------------------------------------------------------
// Reset values, prescale limits (cycles per timer step, minus one) and master clock high steps
// ----------------------------------------------------------------------
`define UBRG_RST_BYTE 8'h00
`define UBRG_RST_PORT_DIR 8'hFF
`define UBRG_RST_PIN_SYNC 3'h7
`define UBRG_RST_PIN_LVL 1'b1
`define UBRG_PRE_ASYNC_LO 6'h3F
`define UBRG_PRE_ASYNC_HI 6'h0F
`define UBRG_PRE_SYNC 6'h03
`define UBRG_PRE_SYNC_HALF 6'h02

`endif

/* src/ubrg_pkg.sv */
// Types for the serial baud generator and port enable block.
// Assumes the constants header is on the include path.
package ubrg_pkg;

    // ------------------------------------------------------------------
    // Bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ubrg_bus_req_t;

    // Receive datapath events, same clock as the block.
    typedef struct packed {
        logic byte_done;
        logic frame_err;
        logic ninth_bit;
        logic overrun;
    } ubrg_rx_evt_t;

    // ------------------------------------------------------------------
    // Rate modes, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        UBRG_MODE_ASYNC_LO = 4'h1,
        UBRG_MODE_ASYNC_HI = 4'h2,
        UBRG_MODE_SYNC_MST = 4'h4,
        UBRG_MODE_SYNC_SLV = 4'h8
    } ubrg_mode_t;

endpackage : ubrg_pkg

/* src/ubrg_top.sv */
// Baud generator, serial pin enabling and receive status for a small USART.
// Assumes i_clk is the oscillator clock and the receive datapath sits outside.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ubrg_consts.svh"

module ubrg_top
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register port
    input wire ubrg_pkg::ubrg_bus_req_t i_bus,
    output logic [7:0] o_rdata,
    // Receive datapath events
    input wire ubrg_pkg::ubrg_rx_evt_t i_rx_evt,
    input wire logic i_tx_shift_empty,
    // Baud timing
    output logic o_baud_tick,
    output logic o_port_active,
    // Receive data pin
    input wire logic i_rx_pin,
    output logic o_rx_pin,
    output logic o_rx_pin_oe,
    // Transmit or clock pin
    input wire logic i_tx_clk_pin,
    output logic o_tx_clk_pin,
    output logic o_tx_clk_pin_oe,
    // Interrupt
    output logic o_irq
);
    import ubrg_pkg::*;

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic ubrg_mode_t mode_of(input logic [7:0] tx_ctrl);
        if (tx_ctrl[`UBRG_TX_SYNC] && tx_ctrl[`UBRG_TX_CLK_SRC])
            return UBRG_MODE_SYNC_MST;
        else if (tx_ctrl[`UBRG_TX_SYNC])
            return UBRG_MODE_SYNC_SLV;
        else if (tx_ctrl[`UBRG_TX_HIGH_SPEED])
            return UBRG_MODE_ASYNC_HI;
        else
            return UBRG_MODE_ASYNC_LO;
    endfunction : mode_of

    function automatic logic hit(input ubrg_bus_req_t req, input logic [7:0] ofs);
        return req.wr && (req.addr == ofs);
    endfunction : hit

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] rx_ctrl_q, rx_ctrl_d;
    logic [7:0] tx_ctrl_q, tx_ctrl_d;
    logic [7:0] divisor_q, divisor_d;
    logic [7:0] port_dir_q, port_dir_d;
    logic [`UBRG_INT_NUM-1:0] int_stat_q, int_stat_d;
    logic [`UBRG_INT_NUM-1:0] int_en_q, int_en_d;
    logic [7:0] rdata_q, rdata_d;
    logic [`UBRG_INT_NUM-1:0] int_evt;
    logic [`UBRG_INT_NUM-1:0] int_clr;
    logic div_wr;
    logic cont_fall;
    ubrg_mode_t mode;

    assign mode = mode_of(tx_ctrl_q);
    assign div_wr = hit(i_bus, `UBRG_OFS_DIVISOR);
    assign cont_fall = hit(i_bus, `UBRG_OFS_RX_CTRL) && rx_ctrl_q[`UBRG_RX_CONT]
                       && !i_bus.wdata[`UBRG_RX_CONT];
    assign int_evt[`UBRG_INT_OVERRUN] = i_rx_evt.overrun;
    assign int_evt[`UBRG_INT_FRAME] = i_rx_evt.byte_done && i_rx_evt.frame_err;
    assign int_clr = hit(i_bus, `UBRG_OFS_INT_CLR) ? i_bus.wdata[`UBRG_INT_NUM-1:0]
                                                   : '0;

    always_comb
    begin
        rx_ctrl_d = rx_ctrl_q;
        tx_ctrl_d = tx_ctrl_q;
        divisor_d = divisor_q;
        port_dir_d = port_dir_q;
        int_en_d = int_en_q;
        if (hit(i_bus, `UBRG_OFS_RX_CTRL))
        begin
            rx_ctrl_d[`UBRG_RX_SERIAL_EN:`UBRG_RX_ADDR_DET] = i_bus.wdata[`UBRG_RX_SERIAL_EN:`UBRG_RX_ADDR_DET];
        end
        if (hit(i_bus, `UBRG_OFS_TX_CTRL))
        begin
            tx_ctrl_d = i_bus.wdata;
            tx_ctrl_d[`UBRG_TX_RSVD] = 1'b0;
            tx_ctrl_d[`UBRG_TX_SHIFT_EMPTY] = 1'b0;
        end
        if (div_wr)
        begin
            divisor_d = i_bus.wdata;
        end
        if (hit(i_bus, `UBRG_OFS_PORT_DIR))
        begin
            port_dir_d = i_bus.wdata;
        end
        if (hit(i_bus, `UBRG_OFS_INT_EN))
        begin
            int_en_d = i_bus.wdata[`UBRG_INT_NUM-1:0];
        end
        // A new event in the same cycle as clearing continuous receive wins.
        if (cont_fall)
        begin
            rx_ctrl_d[`UBRG_RX_OVERRUN] = 1'b0;
        end
        if (i_rx_evt.overrun)
        begin
            rx_ctrl_d[`UBRG_RX_OVERRUN] = 1'b1;
        end
        if (i_rx_evt.byte_done)
        begin
            rx_ctrl_d[`UBRG_RX_FRAME] = i_rx_evt.frame_err;
            rx_ctrl_d[`UBRG_RX_NINTH_BIT] = i_rx_evt.ninth_bit;
        end
    end

    // Sticky interrupt bits: set beats clear in the same cycle.
    genvar gi;
    generate
        for (gi = 0; gi < `UBRG_INT_NUM; gi++)
        begin : g_int
            always_comb
            begin
                int_stat_d[gi] = (int_stat_q[gi] && !int_clr[gi]) || int_evt[gi];
            end
        end
    endgenerate

    always_comb
    begin
        rdata_d = `UBRG_RST_BYTE;
        if (i_bus.rd)
        begin
            case (i_bus.addr)
                `UBRG_OFS_RX_CTRL: rdata_d = rx_ctrl_q;
                `UBRG_OFS_TX_CTRL:
                begin
                    rdata_d = tx_ctrl_q;
                    rdata_d[`UBRG_TX_SHIFT_EMPTY] = i_tx_shift_empty;
                end
                `UBRG_OFS_DIVISOR: rdata_d = divisor_q;
                `UBRG_OFS_PORT_DIR: rdata_d = port_dir_q;
                `UBRG_OFS_INT_STAT: rdata_d[`UBRG_INT_NUM-1:0] = int_stat_q;
                `UBRG_OFS_INT_EN: rdata_d[`UBRG_INT_NUM-1:0] = int_en_q;
                default: rdata_d = `UBRG_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            rx_ctrl_q <= `UBRG_RST_BYTE;
            tx_ctrl_q <= `UBRG_RST_BYTE;
            divisor_q <= `UBRG_RST_BYTE;
            port_dir_q <= `UBRG_RST_PORT_DIR;
            int_stat_q <= '0;
            int_en_q <= '0;
            rdata_q <= `UBRG_RST_BYTE;
        end
        else
        begin
            rx_ctrl_q <= rx_ctrl_d;
            tx_ctrl_q <= tx_ctrl_d;
            divisor_q <= divisor_d;
            port_dir_q <= port_dir_d;
            int_stat_q <= int_stat_d;
            int_en_q <= int_en_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_irq = |(int_stat_q & int_en_q);

    // ------------------------------------------------------------------
    // External clock synchroniser for synchronous slave
    // ------------------------------------------------------------------
    logic [2:0] ext_sync_q, ext_sync_d;
    logic ext_lvl_q, ext_lvl_d;
    logic ext_rise;

    always_comb
    begin
        ext_sync_d = {ext_sync_q[1:0], i_tx_clk_pin};
        ext_lvl_d = ext_lvl_q;
        // The first stage is read only by the second.
        if (ext_sync_q[1] == ext_sync_q[2])
        begin
            ext_lvl_d = ext_sync_q[2];
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            // Start at the idle-high level of the clock pin, so release brings no false edge.
            ext_sync_q <= `UBRG_RST_PIN_SYNC;
            ext_lvl_q <= `UBRG_RST_PIN_LVL;
        end
        else
        begin
            ext_sync_q <= ext_sync_d;
            ext_lvl_q <= ext_lvl_d;
        end
    end

    assign ext_rise = ext_lvl_d && !ext_lvl_q;

    // ------------------------------------------------------------------
    // Baud generator: prescaler then 8-bit timer
    // ------------------------------------------------------------------
    logic [5:0] pre_q, pre_d;
    logic [7:0] timer_q, timer_d;
    logic tick_q, tick_d;
    logic mclk_q, mclk_d;
    logic [5:0] pre_lim;
    logic pre_wrap;

    always_comb
    begin
        case (mode)
            UBRG_MODE_ASYNC_LO: pre_lim = `UBRG_PRE_ASYNC_LO;
            UBRG_MODE_ASYNC_HI: pre_lim = `UBRG_PRE_ASYNC_HI;
            UBRG_MODE_SYNC_MST: pre_lim = `UBRG_PRE_SYNC;
            UBRG_MODE_SYNC_SLV: pre_lim = `UBRG_PRE_SYNC;
            default: pre_lim = `UBRG_PRE_ASYNC_LO;
        endcase
    end

    assign pre_wrap = (pre_q == pre_lim);

    // One timer for every mode; the prescale changes with the mode, and synchronous slave ticks on external clock rises instead.
    always_comb
    begin
        pre_d = pre_wrap ? 6'h00 : pre_q + 6'h01;
        timer_d = timer_q;
        tick_d = 1'b0;
        if (pre_wrap)
        begin
            if (timer_q == divisor_q)
            begin
                timer_d = 8'h00;
                tick_d = 1'b1;
            end
            else
            begin
                timer_d = timer_q + 8'h01;
            end
        end
        // Restarting both stages makes a new divisor govern the very next period.
        if (div_wr)
        begin
            pre_d = 6'h00;
            timer_d = 8'h00;
        end
        // Master clock is high for the first half of timer step zero in each period.
        mclk_d = (timer_d == 8'h00) ? (pre_d < `UBRG_PRE_SYNC_HALF) : mclk_q;
        if (timer_d != 8'h00)
        begin
            mclk_d = 1'b0;
        end
        if (mode == UBRG_MODE_SYNC_SLV)
        begin
            tick_d = ext_rise;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            pre_q <= 6'h00;
            timer_q <= 8'h00;
            tick_q <= 1'b0;
            mclk_q <= 1'b0;
        end
        else
        begin
            pre_q <= pre_d;
            timer_q <= timer_d;
            tick_q <= tick_d;
            mclk_q <= mclk_d;
        end
    end

    assign o_baud_tick = tick_q;

    // ------------------------------------------------------------------
    // Pin enabling
    // ------------------------------------------------------------------
    // Datapaths are outside; pins only show idle levels or the master clock.
    assign o_port_active = rx_ctrl_q[`UBRG_RX_SERIAL_EN] && port_dir_q[`UBRG_DIR_RX_PIN]
                           && port_dir_q[`UBRG_DIR_TX_PIN];
    assign o_rx_pin = 1'b1;
    assign o_rx_pin_oe = 1'b0;
    assign o_tx_clk_pin = (mode == UBRG_MODE_SYNC_MST) ? mclk_q : 1'b1;
    assign o_tx_clk_pin_oe = o_port_active && (mode != UBRG_MODE_SYNC_SLV);

endmodule : ubrg_top

`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the baud generator and pin enable block.
// Assumes design, checker and peer model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
    import ubrg_pkg::*;
    logic i_clk, i_rst_n, run;
    ubrg_bus_req_t bus;
    ubrg_rx_evt_t evt;
    logic [7:0] rdata;
    logic tick, act, rx_o, rx_oe, ck_o, ck_oe, irq, pk, pd;
    int n_fail, check_count, cyc, ticks, pe, n;
    logic [7:0] ra [8] = '{8'h18, 8'h98, 8'h99, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'h55};
    logic [7:0] re [8] = '{8'h00, 8'h02, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] rt [7] = '{16'h0001, 16'h0402, 16'h0400, 16'h0000, 16'h9003, 16'h9403, 16'h90FF};
    int rp [7] = '{128, 48, 16, 64, 16, 16, 1024};
    wire logic ck_w = ck_oe ? ck_o : pk;
    wire logic rx_w = rx_oe ? rx_o : pd;
    ubrg_top dut (.i_clk, .i_rst_n, .i_bus(bus), .o_rdata(rdata), .i_rx_evt(evt), .i_tx_shift_empty(1'b1),
        .o_baud_tick(tick), .o_port_active(act), .i_rx_pin(rx_w), .o_rx_pin(rx_o), .o_rx_pin_oe(rx_oe),
        .i_tx_clk_pin(ck_w), .o_tx_clk_pin(ck_o), .o_tx_clk_pin_oe(ck_oe), .o_irq(irq));
    ubrg_serial_peer peer (.i_clk, .i_run(run), .o_clk_pin(pk), .o_data_pin(pd), .o_edges(pe));
    // ------------------------------------------------------------------
    // Clock, watchdog and access tasks
    // ------------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cyc++;
        if (tick) ticks++;
        if (cyc == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        bus.wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : rd
    task automatic pulse(input ubrg_rx_evt_t v);
        @(posedge i_clk);
        evt <= v;
        @(posedge i_clk);
        evt <= '0;
    endtask : pulse
    // Edges from the call until the next tick.
    task automatic period(output int p);
        p = 0;
        do
        begin
            @(posedge i_clk);
            #1;
            p++;
        end while (!tick && p < 20000);
    endtask : period
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        bus = '0;
        evt = '0;
        run = 1'b0;
        i_rst_n = 1'b0;
        {n_fail, check_count, cyc, ticks} = '0;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        foreach (ra[i]) rd(ra[i], re[i]);
        wr(8'h18, 8'hFF);
        rd(8'h18, 8'hF8);
        wr(8'h98, 8'hFF);
        rd(8'h98, 8'hF7);
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00);
        $display("done: registers");
        foreach (rt[i])
        begin
            wr(8'h98, rt[i][15:8]);
            wr(8'h99, rt[i][7:0]);
            period(n);
            period(n);
            `CHK(n, rp[i])
        end
        wr(8'h98, 8'h00);
        wr(8'h99, 8'hFF);
        repeat (50) @(posedge i_clk);
        wr(8'h99, 8'h00);
        period(n);
        `CHK(n, 64)
        $display("done: rates");
        wr(8'hA0, 8'h00);
        wr(8'h18, 8'h80);
        `CHK(act, 1'b0)
        wr(8'hA0, 8'h06);
        `CHK(act, 1'b1)
        `CHK(ck_oe, 1'b1)
        `CHK({rx_oe, rx_o}, 2'b01)
        wr(8'hA0, 8'h04);
        `CHK(act, 1'b0)
        wr(8'hA0, 8'h06);
        wr(8'h98, 8'h10);
        `CHK(ck_oe, 1'b0)
        repeat (10) @(posedge i_clk);
        n = ticks;
        run <= 1'b1;
        repeat (120) @(posedge i_clk);
        run <= 1'b0;
        repeat (30) @(posedge i_clk);
        `CHK(ticks - n, pe)
        `CHK(pe > 5, 1'b1)
        $display("done: pins");
        wr(8'h18, 8'h90);
        wr(8'hA3, 8'h03);
        pulse(4'h1);
        rd(8'h18, 8'h92);
        `CHK(irq, 1'b1)
        rd(8'hA1, 8'h01);
        wr(8'h18, 8'h90);
        rd(8'h18, 8'h92);
        wr(8'h18, 8'h80);
        rd(8'h18, 8'h80);
        wr(8'hA2, 8'h01);
        `CHK(irq, 1'b0)
        pulse(4'hC);
        rd(8'h18, 8'h84);
        `CHK(irq, 1'b1)
        wr(8'hA3, 8'h01);
        `CHK(irq, 1'b0)
        pulse(4'hA);
        rd(8'h18, 8'h81);
        wr(8'hA2, 8'h02);
        rd(8'hA1, 8'h00);
        // Overrun in the same cycle as the clearing write: the set must win.
        wr(8'h18, 8'h90);
        @(posedge i_clk);
        bus <= '{addr: 8'h18, wdata: 8'h80, wr: 1'b1, rd: 1'b0};
        evt <= 4'h1;
        @(posedge i_clk);
        bus.wr <= 1'b0;
        evt <= '0;
        rd(8'h18, 8'h83);
        `CHK(irq, 1'b1)
        rd(8'hA1, 8'h01);
        $display("done: events");
        complete_run();
    end
endmodule : tb
`default_nettype wire

/* verification/ubrg_assertions.sv */
// Port checker for the baud generator and pin enable block.
// Assumes it is bound onto ubrg_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ubrg_assertions
(
    // Clock, reset and register port
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire ubrg_pkg::ubrg_bus_req_t i_bus,
    // Observed outputs
    input wire logic [7:0] o_rdata,
    input wire logic o_baud_tick,
    input wire logic o_port_active,
    input wire logic o_tx_clk_pin,
    input wire logic o_tx_clk_pin_oe,
    input wire logic o_irq
);
    import ubrg_pkg::*;
    // ------------------------------------------------------------------
    // Register shadows
    // ------------------------------------------------------------------
    logic [7:0] tx_q, div_q, rx_q, dir_q, en_q;
    logic [15:0] cnt_q;
    logic seen_q;
    wire logic slv = tx_q[4] & ~tx_q[7];
    wire logic mst = tx_q[4] & tx_q[7];
    wire logic cfg_wr = i_bus.wr && (i_bus.addr == 8'h98 || i_bus.addr == 8'h99);
    wire logic [15:0] per = (tx_q[4] ? 16'h0004 : tx_q[2] ? 16'h0010 : 16'h0040) * ({8'h00, div_q} + 16'h0001);
    // A mode or divisor write leaves a partial period, so the period check waits for a fresh tick.
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            {tx_q, div_q, rx_q, en_q} <= 32'h00000000;
            dir_q <= 8'hFF;
            cnt_q <= 16'h0000;
            seen_q <= 1'b0;
        end
        else
        begin
            if (i_bus.wr && i_bus.addr == 8'h98) tx_q <= i_bus.wdata;
            if (i_bus.wr && i_bus.addr == 8'h99) div_q <= i_bus.wdata;
            if (i_bus.wr && i_bus.addr == 8'h18) rx_q <= i_bus.wdata;
            if (i_bus.wr && i_bus.addr == 8'hA0) dir_q <= i_bus.wdata;
            if (i_bus.wr && i_bus.addr == 8'hA3) en_q <= i_bus.wdata;
            cnt_q <= o_baud_tick ? 16'h0001 : cnt_q + 16'h0001;
            seen_q <= (seen_q | o_baud_tick) & ~cfg_wr;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
        else $error("read data outside its slot");
    tick_pulse_a: assert property (o_baud_tick |=> !o_baud_tick)
        else $error("baud tick longer than one cycle");
    tick_period_a: assert property (o_baud_tick && seen_q && !slv |-> cnt_q == per)
        else $error("baud period wrong");
    div_restart_a: assert property (i_bus.wr && i_bus.addr == 8'h99 && !slv |=> ##1 !o_baud_tick [*3])
        else $error("tick too soon after divisor write");
    port_act_a: assert property (o_port_active == (rx_q[7] & dir_q[2] & dir_q[1]))
        else $error("port active wrong");
    clk_oe_a: assert property (o_tx_clk_pin_oe == (o_port_active & ~slv))
        else $error("clock pin enable wrong");
    clk_idle_a: assert property (!mst && !$past(mst) |-> o_tx_clk_pin)
        else $error("clock pin not idle");
    mst_clk_a: assert property (mst && o_baud_tick && !cfg_wr ##1 !cfg_wr
        |-> $past(o_tx_clk_pin) && o_tx_clk_pin ##1 !o_tx_clk_pin)
        else $error("master clock shape wrong");
    irq_mask_a: assert property (en_q[1:0] == 2'b00 |-> !o_irq)
        else $error("interrupt while disabled");
    mst_tick_c: cover property (mst && o_baud_tick);
    slv_tick_c: cover property (slv && o_baud_tick);
    irq_c: cover property (o_irq);
endmodule : ubrg_assertions
bind ubrg_top ubrg_assertions chk (.i_clk, .i_rst_n, .i_bus, .o_rdata, .o_baud_tick, .o_port_active,
    .o_tx_clk_pin, .o_tx_clk_pin_oe, .o_irq);
`default_nettype wire

/* verification/ubrg_serial_peer.sv */
// Model of the external serial device on the clock and data pins.
// Assumes the bench resolves each pin from the block's output enable, the peer driving when it is off.
`timescale 1ns/1ps
`default_nettype none
module ubrg_serial_peer
#(
    parameter int HALF = 6
)
(
    // Clock and control
    input wire logic i_clk,
    input wire logic i_run,
    // Pins and edge count
    output logic o_clk_pin,
    output logic o_data_pin,
    output int o_edges
);
    int cnt;
    initial
    begin
        o_clk_pin = 1'b1;
        o_data_pin = 1'b0;
        o_edges = 0;
        cnt = 0;
    end
    // The clock stands high between frames; a started low half always completes.
    always @(posedge i_clk)
    begin
        o_data_pin <= ~o_data_pin;
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1 && (i_run || !o_clk_pin))
        begin
            o_clk_pin <= ~o_clk_pin;
            if (!o_clk_pin) o_edges <= o_edges + 1;
        end
    end
endmodule : ubrg_serial_peer
`default_nettype wire
